// ==== rtl/peiq_event_queue.sv ====
`timescale 1ns/1ps
// Overview of operation
// - serial port receive and transmit completions raise communication events
// - each of four edge inputs raises separate rising and falling events
// - counter match, direction change and external reset events are accepted
// - each pulse train raises an event when its pulse count is done
// - events without a bound handler are ignored
// - periodic timer period is 5 to 255 ms, written before binding
// - two periodic timers, each with its own period byte and event
// - binding a periodic timer latches its period and, only in run mode, enables it
// - rebinding a periodic timer restarts timing with the new period
// - enabled periodic timer reloads and fires once per interval
// - leaving run mode or unbinding stops a periodic timer
// - global interrupt disable does not stop periodic timer queuing
// - ms match timers fire when count becomes equal to target on tick
// - groups rank communication first, then input/output, then timed
// - within a group events are served in queue order; the hold stage moves the lowest held slot first
// - one handler at a time, never preempted
// - events arriving during a handler wait in their group queue
// - queue depths 8, 16 and 8 entries
// - per-queue overflow flag, cleared when empty on return to main
// - port zero events first (rx_char, tx_done, rx_msg), then port one (rx_msg, rx_char, tx_done)
// - fixed in-group ranks for edge, counter, pulse and timed events
// - counter zero match and input zero edges exclude each other
module peiq_event_queue #(
    parameter int COMM_DEPTH = 8,
    parameter int IO_DEPTH = 16,
    parameter int TIMED_DEPTH = 8,
    parameter int TICK_CYCLES = peiq_pkg::TICK_CYCLES
) (
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error on unmapped address
    input wire logic [peiq_pkg::NUM_EDGE-1:0] edge_input_point, // pins
    input wire peiq_pkg::peiq_src_type src_event, // source pulses
    input wire peiq_pkg::peiq_mstmr_type ms_match_timer_a, // timer a
    input wire peiq_pkg::peiq_mstmr_type ms_match_timer_b, // timer b
    output logic handler_active, // a handler runs
    output logic [peiq_pkg::EVT_W-1:0] handler_event, // running event
    output logic comm_queue_overflow_flag, // comm events lost
    output logic io_queue_overflow_flag, // io events lost
    output logic timed_queue_overflow_flag // timed events lost
);
    import peiq_pkg::*;

    localparam int QMAX = (IO_DEPTH > COMM_DEPTH) ?
        ((IO_DEPTH > TIMED_DEPTH) ? IO_DEPTH : TIMED_DEPTH) :
        ((COMM_DEPTH > TIMED_DEPTH) ? COMM_DEPTH : TIMED_DEPTH);
    localparam int CNT_W = $clog2(QMAX + 1);
    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    if (COMM_DEPTH < 1 || IO_DEPTH < 1 || TIMED_DEPTH < 1 ||
        QMAX > 64 || TICK_CYCLES < 2) begin : g_bad_params
        $error("peiq_event_queue: unsupported parameter values");
    end

    typedef struct packed {
        logic [NUM_EDGE-1:0] sync1;
        logic [NUM_EDGE-1:0] sync2;
        logic [NUM_EDGE-1:0] prev;
        logic [NUM_EVENTS-1:0] bound;
        logic run;
        logic gie;
        logic [1:0][7:0] per_wr;
        logic [1:0][7:0] per_lat;
        logic [1:0] pt_en;
        logic [1:0][7:0] pt_cnt;
        logic [TICK_W-1:0] div;
        logic tick;
        logic [1:0] ms_eq;
        logic [NUM_GRP-1:0][NUM_SLOT-1:0] hold;
        logic [NUM_GRP-1:0][QMAX-1:0][EVT_W-1:0] mem;
        logic [NUM_GRP-1:0][CNT_W-1:0] cnt;
        logic [NUM_GRP-1:0] ovf;
        logic busy;
        peiq_evt_type cur;
        logic refused;
        logic [31:0] prdata;
        logic pslverr;
    } peiq_state_type;

    peiq_state_type s_r, s_nxt;

    // maps a group slot to {valid, event number}
    function automatic logic [EVT_W:0] slot_map(input int g, input int sl);
        logic [EVT_W:0] r;
        r = '0;
        if (g == GRP_COMM && sl < COMM_SLOTS) begin
            r = {1'b1, COMM_SLOT[sl]};
        end else if (g == GRP_IO && sl < IO_SLOTS) begin
            r = {1'b1, IO_SLOT[sl]};
        end else if (g == GRP_TIMED && sl < TIMED_SLOTS) begin
            r = {1'b1, TIMED_SLOT[sl]};
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] qdepth(input int g);
        logic [CNT_W-1:0] d;
        d = CNT_W'(TIMED_DEPTH);
        if (g == GRP_COMM) begin
            d = CNT_W'(COMM_DEPTH);
        end else if (g == GRP_IO) begin
            d = CNT_W'(IO_DEPTH);
        end
        return d;
    endfunction

    logic [NUM_EDGE-1:0] rise, fall;
    logic [NUM_EVENTS-1:0] raw;
    logic [1:0] pt_fire, ms_fire, ms_eq_now;
    logic [NUM_GRP-1:0] take, drop;
    logic [NUM_GRP-1:0][EVT_W-1:0] take_evt;
    logic [EVT_W:0] m;
    logic wr_acc, setup, ret_wr, dispatch, bind_wr, attach_ok;
    peiq_evt_type bind_evt;
    peiq_mstmr_type [1:0] mstmr;
    assign mstmr[0] = ms_match_timer_a;
    assign mstmr[1] = ms_match_timer_b;
    always_comb begin
        s_nxt = s_r;
        // the first stage is only ever copied into the second
        s_nxt.sync1 = edge_input_point;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        rise = s_r.sync2 & ~s_r.prev;
        fall = ~s_r.sync2 & s_r.prev;
        // 1 ms system tick
        s_nxt.tick = 1'b0;
        if (s_r.div == TICK_LAST) begin
            s_nxt.div = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 1'b1;
        end
        // match timers fire on the update that first sees equality
        for (int t = 0; t < 2; t++) begin
            ms_eq_now[t] = mstmr[t].count_value == mstmr[t].target_value;
            ms_fire[t] = s_r.tick & ms_eq_now[t] & ~s_r.ms_eq[t];
            if (s_r.tick) begin
                s_nxt.ms_eq[t] = ms_eq_now[t];
            end
        end
        for (int t = 0; t < 2; t++) begin
            pt_fire[t] = 1'b0;
            if (s_r.pt_en[t] && s_r.tick) begin
                if (s_r.pt_cnt[t] + 8'h01 >= s_r.per_lat[t]) begin
                    pt_fire[t] = 1'b1;
                    s_nxt.pt_cnt[t] = '0;
                end else begin
                    s_nxt.pt_cnt[t] = s_r.pt_cnt[t] + 8'h01;
                end
            end
        end
        if (!s_r.run) begin
            s_nxt.pt_en = '0;
        end
        raw = '0;
        for (int i = 0; i < NUM_EDGE; i++) begin
            raw[2*i] = rise[i];
            raw[2*i+1] = fall[i];
        end
        raw[EV_P0_RX_CHAR] = src_event.rx_char[0];
        raw[EV_P0_TX_DONE] = src_event.tx_done[0];
        raw[EV_P0_RX_MSG] = src_event.rx_msg[0];
        raw[EV_P1_RX_CHAR] = src_event.rx_char[1];
        raw[EV_P1_TX_DONE] = src_event.tx_done[1];
        raw[EV_P1_RX_MSG] = src_event.rx_msg[1];
        raw[EV_CNT0_MATCH] = src_event.cnt_match[0];
        raw[EV_CNT1_MATCH] = src_event.cnt_match[1];
        raw[EV_CNT2_MATCH] = src_event.cnt_match[2];
        raw[EV_CNT1_DIR] = src_event.cnt_dir[0];
        raw[EV_CNT2_DIR] = src_event.cnt_dir[1];
        raw[EV_CNT1_RESET] = src_event.cnt_ext_reset[0];
        raw[EV_CNT2_RESET] = src_event.cnt_ext_reset[1];
        raw[EV_PULSE0] = src_event.pulse_done[0];
        raw[EV_PULSE1] = src_event.pulse_done[1];
        raw[EV_PTIMER0] = pt_fire[0];
        raw[EV_PTIMER1] = pt_fire[1];
        raw[EV_MSTMR_A] = ms_fire[0];
        raw[EV_MSTMR_B] = ms_fire[1];
        // apb: zero wait states, read data prepared in the setup cycle
        setup = psel & ~penable;
        wr_acc = psel & penable & pwrite;
        bind_wr = wr_acc && paddr == OFS_BIND;
        ret_wr = wr_acc && paddr == OFS_DISPATCH;
        bind_evt = pwdata[EVT_W-1:0];
        attach_ok = 1'b0;
        if (wr_acc && paddr == OFS_CTRL) begin
            s_nxt.run = pwdata[CTRL_RUN_BIT];
            s_nxt.gie = pwdata[CTRL_GIE_BIT];
        end else if (wr_acc && paddr == OFS_PERIOD0) begin
            s_nxt.per_wr[0] = pwdata[7:0];
        end else if (wr_acc && paddr == OFS_PERIOD1) begin
            s_nxt.per_wr[1] = pwdata[7:0];
        end
        if (bind_wr && pwdata[BIND_ATTACH_BIT]) begin
            attach_ok = bind_evt < EVT_W'(NUM_EVENTS);
            if (bind_evt == EV_CNT0_MATCH &&
                (s_r.bound[EV_RISE0] || s_r.bound[EV_FALL0])) begin
                attach_ok = 1'b0;
            end
            if ((bind_evt == EV_RISE0 || bind_evt == EV_FALL0) &&
                s_r.bound[EV_CNT0_MATCH]) begin
                attach_ok = 1'b0;
            end
            for (int t = 0; t < 2; t++) begin
                if (bind_evt == EV_PTIMER0 + EVT_W'(t) &&
                    s_r.per_wr[t] < PERIOD_MIN) begin
                    attach_ok = 1'b0;
                end
            end
            s_nxt.refused = ~attach_ok;
            if (attach_ok) begin
                s_nxt.bound[bind_evt] = 1'b1;
                for (int t = 0; t < 2; t++) begin
                    if (bind_evt == EV_PTIMER0 + EVT_W'(t)) begin
                        s_nxt.per_lat[t] = s_r.per_wr[t];
                        s_nxt.pt_cnt[t] = '0;
                        s_nxt.pt_en[t] = s_r.run;
                    end
                end
            end
        end else if (bind_wr && bind_evt < EVT_W'(NUM_EVENTS)) begin
            s_nxt.bound[bind_evt] = 1'b0;
            for (int t = 0; t < 2; t++) begin
                if (bind_evt == EV_PTIMER0 + EVT_W'(t)) begin
                    s_nxt.pt_en[t] = 1'b0;
                end
            end
        end
        // return from handler; flags clear only for queues left empty
        if (ret_wr && s_r.busy) begin
            s_nxt.busy = 1'b0;
            for (int g = 0; g < NUM_GRP; g++) begin
                if (s_r.cnt[g] == '0) begin
                    s_nxt.ovf[g] = 1'b0;
                end
            end
        end
        // start the next handler only once none is running
        dispatch = 1'b0;
        if (!s_r.busy && s_r.run && s_r.gie) begin
            for (int g = 0; g < NUM_GRP; g++) begin
                if (!dispatch && s_r.cnt[g] != '0) begin
                    dispatch = 1'b1;
                    s_nxt.busy = 1'b1;
                    s_nxt.cur = s_r.mem[g][0];
                    for (int i = 0; i < QMAX - 1; i++) begin
                        s_nxt.mem[g][i] = s_r.mem[g][i+1];
                    end
                    s_nxt.cnt[g] = s_r.cnt[g] - 1'b1;
                end
            end
        end
        // one latched event per group moves into its queue per cycle;
        // the hold stage costs a cycle but keeps one write port per queue
        for (int g = 0; g < NUM_GRP; g++) begin
            take[g] = 1'b0;
            take_evt[g] = '0;
            drop[g] = 1'b0;
            for (int sl = 0; sl < NUM_SLOT; sl++) begin
                m = slot_map(g, sl);
                if (!take[g] && s_r.hold[g][sl]) begin
                    take[g] = 1'b1;
                    take_evt[g] = m[EVT_W-1:0];
                    s_nxt.hold[g][sl] = 1'b0;
                end
            end
            for (int sl = 0; sl < NUM_SLOT; sl++) begin
                m = slot_map(g, sl);
                if (m[EVT_W] && raw[m[EVT_W-1:0]] &&
                    s_r.bound[m[EVT_W-1:0]]) begin
                    if (s_nxt.hold[g][sl]) begin
                        drop[g] = 1'b1;
                    end else begin
                        s_nxt.hold[g][sl] = 1'b1;
                    end
                end
            end
            if (take[g]) begin
                if (s_nxt.cnt[g] >= qdepth(g)) begin
                    drop[g] = 1'b1;
                end else begin
                    s_nxt.mem[g][s_nxt.cnt[g]] = take_evt[g];
                    s_nxt.cnt[g] = s_nxt.cnt[g] + 1'b1;
                end
            end
            // a loss in the same cycle as the clear keeps the flag set
            if (drop[g]) begin
                s_nxt.ovf[g] = 1'b1;
            end
        end

        if (setup) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = '0;
            if (paddr == OFS_CTRL) begin
                s_nxt.prdata[CTRL_RUN_BIT] = s_r.run;
                s_nxt.prdata[CTRL_GIE_BIT] = s_r.gie;
            end else if (paddr == OFS_BIND) begin
                s_nxt.prdata = '0;
            end else if (paddr == OFS_BOUND) begin
                s_nxt.prdata[NUM_EVENTS-1:0] = s_r.bound;
            end else if (paddr == OFS_PERIOD0) begin
                s_nxt.prdata[7:0] = s_r.per_wr[0];
            end else if (paddr == OFS_PERIOD1) begin
                s_nxt.prdata[7:0] = s_r.per_wr[1];
            end else if (paddr == OFS_STATUS) begin
                s_nxt.prdata[NUM_GRP-1:0] = s_r.ovf;
                s_nxt.prdata[STAT_BUSY_BIT] = s_r.busy;
                s_nxt.prdata[STAT_REFUSED_BIT] = s_r.refused;
            end else if (paddr == OFS_DISPATCH) begin
                s_nxt.prdata[DISP_VALID_BIT] = s_r.busy;
                s_nxt.prdata[EVT_W-1:0] = s_r.cur;
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready = 1'b1;
    assign prdata = s_r.prdata;
    assign pslverr = psel & penable & s_r.pslverr;
    assign handler_active = s_r.busy;
    assign handler_event = s_r.cur;
    assign comm_queue_overflow_flag = s_r.ovf[GRP_COMM];
    assign io_queue_overflow_flag = s_r.ovf[GRP_IO];
    assign timed_queue_overflow_flag = s_r.ovf[GRP_TIMED];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence attach_pt0_s;
        bind_wr && pwdata[BIND_ATTACH_BIT] && bind_evt == EV_PTIMER0 &&
            attach_ok && s_r.run;
    endsequence
    sequence pt0_running_s;
        s_r.pt_en[0] && s_r.pt_cnt[0] == 8'h00;
    endsequence
    edge_to_hold_a: assert property (
        rise[0] && s_r.bound[EV_RISE0] |=> s_r.hold[GRP_IO][0] ||
            s_r.cnt[GRP_IO] != $past(s_r.cnt[GRP_IO]) || s_r.ovf[GRP_IO])
        else $error("rising edge of point 0 not captured");
    unbound_drop_a: assert property (
        !s_r.bound[EV_PULSE0] && !s_r.hold[GRP_IO][15] |=>
            !s_r.hold[GRP_IO][15])
        else $error("unbound pulse event was latched");
    period_latch_a: assert property (
        attach_pt0_s |=> pt0_running_s and
            (s_r.per_lat[0] == $past(s_r.per_wr[0])))
        else $error("periodic timer 0 did not latch and start");
    // a run drop or bind in the firing cycle legally changes the enable
    period_reload_a: assert property (
        pt_fire[0] && s_r.run && !bind_wr |=>
            s_r.pt_cnt[0] == 8'h00 && s_r.pt_en[0])
        else $error("periodic timer did not reload");
    stop_mode_a: assert property (
        !s_r.run |=> s_r.pt_en == 2'b00)
        else $error("periodic timer still running outside run mode");
    gie_no_stop_a: assert property (
        pt_fire[0] && s_r.bound[EV_PTIMER0] && !s_r.gie &&
            !s_r.hold[GRP_TIMED][0] |=> s_r.hold[GRP_TIMED][0])
        else $error("timed event lost while interrupts disabled");
    no_preempt_a: assert property (
        s_r.busy && !ret_wr |=> s_r.busy && $stable(s_r.cur))
        else $error("running handler was replaced");
    comm_first_a: assert property (
        dispatch && s_r.cnt[GRP_COMM] != '0 |=>
            s_r.cur == $past(s_r.mem[GRP_COMM][0]))
        else $error("communication queue not served first");
    full_drop_a: assert property (
        drop[GRP_TIMED] |=> s_r.ovf[GRP_TIMED] ##1
            (s_r.ovf[GRP_TIMED] || $past(ret_wr)))
        else $error("overflow flag not raised on dropped event");
    exclusive_bind_a: assert property (
        bind_wr && pwdata[BIND_ATTACH_BIT] && bind_evt == EV_CNT0_MATCH &&
            s_r.bound[EV_RISE0] |=> !s_r.bound[EV_CNT0_MATCH] && s_r.refused)
        else $error("conflicting counter match bind accepted");
endmodule // peiq_event_queue

// ==== rtl/peiq_pkg.sv ====
package peiq_pkg;

    localparam int EVT_W = 5;
    localparam int NUM_EVENTS = 27;
    localparam int NUM_GRP = 3;
    localparam int NUM_EDGE = 4;
    localparam int NUM_SLOT = 17;
    localparam int COMM_SLOTS = 6;
    localparam int IO_SLOTS = 17;
    localparam int TIMED_SLOTS = 4;

    typedef logic [EVT_W-1:0] peiq_evt_type;

    // queue groups, highest priority first
    localparam int GRP_COMM = 0;
    localparam int GRP_IO = 1;
    localparam int GRP_TIMED = 2;

    // event numbers
    localparam peiq_evt_type EV_RISE0 = 5'h00;
    localparam peiq_evt_type EV_FALL0 = 5'h01;
    localparam peiq_evt_type EV_P0_RX_CHAR = 5'h08;
    localparam peiq_evt_type EV_P0_TX_DONE = 5'h09;
    localparam peiq_evt_type EV_PTIMER0 = 5'h0A;
    localparam peiq_evt_type EV_PTIMER1 = 5'h0B;
    localparam peiq_evt_type EV_CNT0_MATCH = 5'h0C;
    localparam peiq_evt_type EV_CNT1_MATCH = 5'h0D;
    localparam peiq_evt_type EV_CNT1_DIR = 5'h0E;
    localparam peiq_evt_type EV_CNT1_RESET = 5'h0F;
    localparam peiq_evt_type EV_CNT2_MATCH = 5'h10;
    localparam peiq_evt_type EV_CNT2_DIR = 5'h11;
    localparam peiq_evt_type EV_CNT2_RESET = 5'h12;
    localparam peiq_evt_type EV_PULSE0 = 5'h13;
    localparam peiq_evt_type EV_PULSE1 = 5'h14;
    localparam peiq_evt_type EV_MSTMR_A = 5'h15;
    localparam peiq_evt_type EV_MSTMR_B = 5'h16;
    localparam peiq_evt_type EV_P0_RX_MSG = 5'h17;
    localparam peiq_evt_type EV_P1_RX_MSG = 5'h18;
    localparam peiq_evt_type EV_P1_RX_CHAR = 5'h19;
    localparam peiq_evt_type EV_P1_TX_DONE = 5'h1A;

    // in-group service order for events that arrive together
    localparam peiq_evt_type COMM_SLOT [COMM_SLOTS] = '{
        EV_P0_RX_CHAR, EV_P0_TX_DONE, EV_P0_RX_MSG,
        EV_P1_RX_MSG, EV_P1_RX_CHAR, EV_P1_TX_DONE};
    localparam peiq_evt_type IO_SLOT [IO_SLOTS] = '{
        5'h00, EV_CNT0_MATCH, 5'h02, 5'h04, 5'h06, 5'h01, 5'h03, 5'h05,
        5'h07, EV_CNT1_MATCH, EV_CNT1_DIR, EV_CNT1_RESET, EV_CNT2_MATCH,
        EV_CNT2_DIR, EV_CNT2_RESET, EV_PULSE0, EV_PULSE1};
    localparam peiq_evt_type TIMED_SLOT [TIMED_SLOTS] = '{
        EV_PTIMER0, EV_PTIMER1, EV_MSTMR_A, EV_MSTMR_B};

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_BIND = 12'h004;
    localparam logic [11:0] OFS_BOUND = 12'h008;
    localparam logic [11:0] OFS_PERIOD0 = 12'h00C;
    localparam logic [11:0] OFS_PERIOD1 = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_DISPATCH = 12'h018;

    // field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_GIE_BIT = 1;
    localparam int BIND_ATTACH_BIT = 8;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_REFUSED_BIT = 4;
    localparam int DISP_VALID_BIT = 31;

    // reset value and minimum of the period byte
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    localparam logic [7:0] PERIOD_MIN = 8'h05;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] rx_char;
        logic [1:0] tx_done;
        logic [1:0] rx_msg;
        logic [2:0] cnt_match;
        logic [1:0] cnt_dir;
        logic [1:0] cnt_ext_reset;
        logic [1:0] pulse_done;
    } peiq_src_type;

    typedef struct packed {
        logic [15:0] count_value;
        logic [15:0] target_value;
    } peiq_mstmr_type;

endpackage

// ==== test/peiq_program_model.sv ====
`timescale 1ns/1ps
module peiq_program_model (
    input wire logic pclk, // clock
    input wire logic handler_active, // a handler runs
    input wire logic [peiq_pkg::EVT_W-1:0] handler_event // running event
);
    import peiq_pkg::*;
    logic was_r = 1'b0;
    int seen[$];
    // the program logs each routine it enters; one entry per start
    always @(posedge pclk) begin
        if (handler_active === 1'b1 && was_r !== 1'b1) begin
            seen.push_back(int'(handler_event));
        end
        was_r <= handler_active;
    end
endmodule // peiq_program_model

// ==== test/plc_event_interrupt_queue_tb_top.sv ====
`timescale 1ns/1ps
module plc_event_interrupt_queue_tb_top;
    import peiq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, se, act, cq, iq, tq;
    logic [4:0] hev;
    logic [3:0] pins = 4'h0;
    peiq_src_type src = 15'h0;
    peiq_mstmr_type ta = 32'h0;
    peiq_mstmr_type tm_b = 32'h0;
    int n_errors = 0;
    int comparisons = 0;
    int exp_q[$];
    int k;
    always #10 pclk = ~pclk;
    peiq_event_queue #(.COMM_DEPTH(2), .TICK_CYCLES(20)) u_dut (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .edge_input_point(pins), .src_event(src),
        .ms_match_timer_a(ta), .ms_match_timer_b(tm_b),
        .handler_active(act), .handler_event(hev),
        .comm_queue_overflow_flag(cq), .io_queue_overflow_flag(iq),
        .timed_queue_overflow_flag(tq));
    peiq_program_model u_prog (.pclk, .handler_active(act),
        .handler_event(hev));
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        src[b] <= 1'b1;
        @(posedge pclk);
        src <= 15'h0;
        repeat (3) @(posedge pclk);
    endtask
    // wait for the next routine, then return from it
    task automatic serve(input int ev);
        int n;
        n = 0;
        exp_q.push_back(ev);
        while (act !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(n < 400, 1'b1);
        apb(1'b1, OFS_DISPATCH, 32'h0);
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        #(20 * 20000);
        n_errors++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h24385736));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk({cq, iq, tq, act}, 4'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk({se, rd}, {1'b1, 32'h0});
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_BIND, 32'h100);
        apb(1'b1, OFS_BIND, 32'h10C);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[STAT_REFUSED_BIT], 1'b1);
        apb(1'b1, OFS_PERIOD0, 32'h4);
        apb(1'b1, OFS_BIND, 32'h10A);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[STAT_REFUSED_BIT], 1'b1);
        apb(1'b1, OFS_BIND, 32'h113);
        apb(1'b1, OFS_BIND, 32'h108);
        apb(1'b1, OFS_BIND, 32'h101);
        apb(1'b1, OFS_BIND, 32'h115);
        apb(1'b1, OFS_BIND, 32'h116);
        apb(1'b0, OFS_BOUND, 32'h0);
        chk(rd, 32'h0068_0103);
        pulse(0);
        pulse(14);
        pulse(13);
        apb(1'b1, OFS_CTRL, 32'h3);
        serve(8);
        serve(19);
        apb(1'b1, OFS_CTRL, 32'h1);
        k = 3 + $urandom_range(2);
        repeat (k) pulse(13);
        chk(cq, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h3);
        serve(8);
        chk(cq, 1'b1);
        serve(8);
        chk(cq, 1'b0);
        pins <= 4'h1;
        serve(0);
        pins <= 4'h0;
        serve(1);
        apb(1'b1, OFS_PERIOD0, 32'h5);
        apb(1'b1, OFS_BIND, 32'h10A);
        apb(1'b1, OFS_PERIOD0, 32'hFF);
        serve(10);
        serve(10);
        // one expiry falls while interrupts are off and must still queue
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (120) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 32'h3);
        serve(10);
        apb(1'b1, OFS_BIND, 32'h00A);
        ta <= {16'h0001, 16'h0005};
        tm_b <= {16'h0001, 16'h0005};
        repeat (45) @(posedge pclk);
        ta.count_value <= 16'h0005;
        tm_b.count_value <= 16'h0005;
        serve(21);
        serve(22);
        repeat (300) @(posedge pclk);
        chk(act, 1'b0);
        chk(u_prog.seen.size(), exp_q.size());
        foreach (exp_q[i]) begin
            if (i < u_prog.seen.size()) chk(u_prog.seen[i], exp_q[i]);
        end
        end_sim;
    end
endmodule // plc_event_interrupt_queue_tb_top
